// ==== src/sdc_ctrl.sv ====
// Host controller that powers up, programs and drives a four-bank 16-bit SDRAM.
// Assumes the memory samples its pins at the rising edge of sd_clk, made here as clk divided by two.
`timescale 1ns/1ps
module sdc_ctrl
  import sdc_pkg::*;
#(
  parameter int INIT_TICKS = INIT_WAIT_TICKS
) (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              srst,
  // Configuration taken at power-up.
  input  wire logic              cfg_lat3,
  input  wire logic [1:0]        cfg_drive,
  // Request stream.
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire sdc_req_t          req,
  // Read answers and status.
  output logic                   rd_valid,
  output logic [DATA_W-1:0]      rd_data,
  output logic                   init_done,
  // Memory pins.
  output logic                   sd_clk,
  output sdc_pins_t              sd_pins,
  input  wire logic [DATA_W-1:0] sd_dq_in
);

  typedef struct packed {
    sdc_state_t        st;
    logic              ph;
    logic [12:0]       wcnt;
    logic [7:0]        refcnt;
    logic              ref_due;
    logic [1:0]        refs;
    logic [2:0]        lat;
    logic [1:0]        drive;
    sdc_req_t          cur;
    sdc_pins_t         pins;
    logic              rd_valid;
    logic [DATA_W-1:0] rd_data;
    logic              init_done;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
  } sdc_ctrl_state_t;

  sdc_ctrl_state_t s;
  sdc_ctrl_state_t next_s;
  logic            pop;
  logic            fifo_valid;
  sdc_req_t        fifo_data;

  sdc_fifo #(
    .W ($bits(sdc_req_t)),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .in_data   (req),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data)
  );

  // Builds a command from a strobe pattern and an address.
  function automatic sdc_pins_t make_cmd(input logic [2:0] rcw, input logic [PIN_ADDR_W-1:0] a);
    sdc_pins_t p;
    p = PINS_NOP;
    {p.ras_n, p.cas_n, p.we_n} = rcw;
    p.addr = a;
    return p;
  endfunction

  // Places a bank code for the bank lines; bank[1] drives A12, bank[0] drives A13.
  function automatic logic [1:0] bank_lines(input logic [1:0] b);
    return {b[0], b[1]};
  endfunction

  // Mode word; every bit not named stays low.
  function automatic logic [PIN_ADDR_W-1:0] mode_word(input logic [2:0] lat);
    logic [PIN_ADDR_W-1:0] m;
    m = '0;
    m[MODE_LAT_LSB +: 3] = lat;
    m[MODE_ORDER_BIT] = ORDER_SEQ;
    m[MODE_LEN_LSB +: 3] = LEN1;
    m[MODE_WRITE_BIT] = WRITE_SINGLE;
    return m;
  endfunction

  // Extended mode word with A12 high, the drive code at A6:A5 and everything else low.
  function automatic logic [PIN_ADDR_W-1:0] ext_word(input logic [1:0] drv);
    logic [PIN_ADDR_W-1:0] m;
    m = '0;
    m[EXT_DRIVE_LSB +: 2] = drv;
    m[PIN_ADDR_W-2] = 1'h1;
    return m;
  endfunction

  always_comb begin
    next_s = s;
    pop = 1'h0;
    next_s.dq_s1 = sd_dq_in;
    next_s.dq_s2 = s.dq_s1;
    next_s.rd_valid = 1'h0;
    next_s.ph = ~s.ph;
    // Pins change as sd_clk falls, half a period ahead of the sampling edge.
    if (s.ph) begin
      next_s.pins = PINS_NOP;
      if (s.wcnt != '0) begin
        next_s.wcnt = s.wcnt - 13'h1;
      end else begin
        case (s.st)
          S_START: begin
            next_s.lat = cfg_lat3 ? LAT3 : LAT2;
            next_s.drive = (cfg_drive == DRIVE_RSVD) ? DRIVE_QUARTER : cfg_drive;
            next_s.wcnt = 13'(INIT_TICKS - 1);
            next_s.st = S_PWR_WAIT;
          end
          S_PWR_WAIT: begin
            next_s.pins = make_cmd(CMD_CLOSE, 14'(1 << AUTOCLOSE_BIT));
            next_s.wcnt = 13'(PRECHARGE_TICKS - 1);
            next_s.st = S_INIT_REF;
          end
          S_INIT_REF: begin
            next_s.pins = make_cmd(CMD_REFRESH, '0);
            next_s.wcnt = 13'(REFRESH_CYCLE_TICKS - 1);
            next_s.refs = s.refs + 2'h1;
            if (s.refs == 2'(INIT_REFRESHES - 1)) begin
              next_s.st = S_INIT_MODE;
            end
          end
          S_INIT_MODE: begin
            next_s.pins = make_cmd(CMD_MODE, mode_word(s.lat));
            next_s.wcnt = 13'(MODE_TO_CMD_TICKS - 1);
            next_s.st = S_INIT_EXT;
          end
          S_INIT_EXT: begin
            next_s.pins = make_cmd(CMD_MODE, ext_word(s.drive));
            next_s.wcnt = 13'(MODE_TO_CMD_TICKS - 1);
            next_s.init_done = 1'h1;
            next_s.st = S_IDLE;
          end
          S_IDLE: begin
            if (s.ref_due) begin
              next_s.pins = make_cmd(CMD_REFRESH, '0);
              next_s.ref_due = 1'h0;
              next_s.wcnt = 13'(REFRESH_CYCLE_TICKS - 1);
            end else if (fifo_valid) begin
              pop = 1'h1;
              next_s.cur = fifo_data;
              next_s.pins = make_cmd(CMD_ROW_OPEN, {bank_lines(fifo_data.bank), fifo_data.row});
              next_s.wcnt = 13'(ROW_TO_COL_TICKS - 1);
              next_s.st = S_COLUMN;
            end
          end
          S_COLUMN: begin
            if (s.cur.we) begin
              next_s.pins = make_cmd(CMD_WRITE, {bank_lines(s.cur.bank), 4'h0, s.cur.col});
              next_s.pins.dq = s.cur.wdata;
              next_s.pins.dq_oe = 1'h1;
              next_s.wcnt = 13'(WRITE_CLOSE_GAP - 1);
              next_s.st = S_CLOSE;
            end else begin
              next_s.pins = make_cmd(CMD_READ, {bank_lines(s.cur.bank), 4'h0, s.cur.col});
              next_s.wcnt = {10'h0, s.lat};
              next_s.st = S_READ_WAIT;
            end
          end
          S_READ_WAIT: begin
            next_s.rd_data = s.dq_s2;
            next_s.rd_valid = 1'h1;
            next_s.st = S_CLOSE;
          end
          S_CLOSE: begin
            next_s.pins = make_cmd(CMD_CLOSE, {bank_lines(s.cur.bank), 12'h0});
            next_s.wcnt = 13'(PRECHARGE_TICKS - 1);
            next_s.st = S_IDLE;
          end
          default: begin
            next_s.st = S_START;
          end
        endcase
      end
      // Refresh interval timer; a new due flag wins over the clear above.
      if (s.init_done) begin
        if (s.refcnt == 8'(REFRESH_TICKS - 1)) begin
          next_s.refcnt = 8'h0;
          next_s.ref_due = 1'h1;
        end else begin
          next_s.refcnt = s.refcnt + 8'h1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '{st: S_START, pins: PINS_NOP, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign rd_valid = s.rd_valid;
  assign rd_data = s.rd_data;
  assign init_done = s.init_done;
  assign sd_clk = s.ph;
  assign sd_pins = s.pins;

  // Checks below watch the pins in the first clock of each memory period.
  logic [12:0] h_nop_ticks;
  logic [1:0]  h_refs;
  logic        h_close_all;
  logic        h_mode;
  logic        h_open;
  logic [2:0]  h_open_age;
  logic [8:0]  h_ref_age;
  logic        h_cmd;
  logic        h_mode_load;
  logic        h_ext_load;
  logic        h_row_open;
  logic        h_pre;
  logic        h_ref;
  logic        h_rd;
  logic        h_wr;

  assign h_cmd = ~s.ph & ~s.pins.cs_n & ~(s.pins.ras_n & s.pins.cas_n & s.pins.we_n);
  assign h_mode_load = h_cmd && ({s.pins.ras_n, s.pins.cas_n, s.pins.we_n} == CMD_MODE) && (s.pins.addr[13:12] == 2'h0);
  assign h_ext_load = h_cmd && ({s.pins.ras_n, s.pins.cas_n, s.pins.we_n} == CMD_MODE) && (s.pins.addr[13:12] == 2'h1);
  assign h_row_open = h_cmd && ({s.pins.ras_n, s.pins.cas_n, s.pins.we_n} == CMD_ROW_OPEN);
  assign h_pre = h_cmd && ({s.pins.ras_n, s.pins.cas_n, s.pins.we_n} == CMD_CLOSE);
  assign h_ref = h_cmd && ({s.pins.ras_n, s.pins.cas_n, s.pins.we_n} == CMD_REFRESH);
  assign h_rd = h_cmd && ({s.pins.ras_n, s.pins.cas_n, s.pins.we_n} == CMD_READ);
  assign h_wr = h_cmd && ({s.pins.ras_n, s.pins.cas_n, s.pins.we_n} == CMD_WRITE);

  always_ff @(posedge clk) begin
    if (srst) begin
      h_nop_ticks <= 13'h0;
      h_refs <= 2'h0;
      h_close_all <= 1'h0;
      h_mode <= 1'h0;
      h_open <= 1'h0;
      h_open_age <= 3'h7;
      h_ref_age <= 9'h0;
    end else if (~s.ph) begin
      if (h_nop_ticks != 13'h1FFF) begin
        h_nop_ticks <= h_nop_ticks + 13'h1;
      end
      if (h_ref && !h_mode && h_refs != 2'h3) begin
        h_refs <= h_refs + 2'h1;
      end
      if (h_pre && s.pins.addr[AUTOCLOSE_BIT]) begin
        h_close_all <= 1'h1;
      end
      if (h_mode_load) begin
        h_mode <= 1'h1;
      end
      if (h_row_open) begin
        h_open <= 1'h1;
      end else if (h_pre) begin
        h_open <= 1'h0;
      end
      if (h_row_open) begin
        h_open_age <= 3'h1;
      end else if (h_open_age != 3'h7) begin
        h_open_age <= h_open_age + 3'h1;
      end
      if (h_ref || !s.init_done) begin
        h_ref_age <= 9'h1;
      end else if (h_ref_age != 9'h1FF) begin
        h_ref_age <= h_ref_age + 9'h1;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  chk_power_up_wait: assert property (h_cmd |-> h_nop_ticks >= 13'(INIT_TICKS))
    else $error("Command issued before the power-up wait ended.");
  chk_init_order_seq: assert property (h_mode_load |-> h_close_all && h_refs >= 2'h2)
    else $error("Mode load without close-all and two refreshes first.");
  chk_mode_before_use: assert property ((h_row_open || h_rd || h_wr) |-> h_mode)
    else $error("Access before the mode register was loaded.");
  chk_mode_word_legal: assert property (h_mode_load |-> s.pins.addr[11:10] == 2'h0 && s.pins.addr[8:7] == 2'h0
    && (s.pins.addr[6:4] == LAT2 || s.pins.addr[6:4] == LAT3) && s.pins.addr[2:0] == LEN1
    && s.pins.addr[9] == WRITE_SINGLE)
    else $error("Mode word holds a reserved code or a set reserved bit.");
  chk_ext_word_legal: assert property (h_ext_load |-> s.pins.addr[4:0] == 5'h0 && s.pins.addr[11:7] == 5'h0
    && s.pins.addr[6:5] != DRIVE_RSVD)
    else $error("Extended mode word holds a reserved code or a set bit.");
  chk_ext_after_mode: assert property (h_mode_load |-> ##4 h_ext_load)
    else $error("Extended mode load did not follow the mode load.");
  chk_row_to_col: assert property ((h_rd || h_wr) |-> h_open_age >= 3'(ROW_TO_COL_TICKS))
    else $error("Column command too soon after row open.");
  chk_close_after_act: assert property (h_pre && h_open |-> h_open_age >= 3'(MIN_ACTIVE_TICKS))
    else $error("Close issued before the minimum active time.");
  chk_refresh_idle: assert property (h_ref |-> !h_open)
    else $error("Refresh issued with a bank open.");
  chk_refresh_rate: assert property (s.init_done |-> h_ref_age <= 9'(REFRESH_TICKS + 12))
    else $error("Refresh interval exceeded.");
  chk_read_lat2: assert property (h_rd && s.lat == LAT2 |-> ##5 !rd_valid ##1 rd_valid)
    else $error("Read data not taken after latency two.");
  chk_read_lat3: assert property (h_rd && s.lat == LAT3 |-> ##7 !rd_valid ##1 rd_valid)
    else $error("Read data not taken after latency three.");
  chk_write_data: assert property (h_wr |-> s.pins.dq_oe && !s.pins.addr[AUTOCLOSE_BIT] ##1 s.pins.dq_oe)
    else $error("Write data not driven with the write command.");

  cov_init_done: cover property ($rose(s.init_done));
  cov_read: cover property (h_rd ##[1:20] rd_valid);
  cov_write: cover property (h_wr);
  cov_refresh: cover property (s.init_done && h_ref);

endmodule

// ==== src/sdc_fifo.sv ====
// Small request buffer with valid and ready at both sides.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
module sdc_fifo #(
  parameter int W = 39,
  parameter int D = 4
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         srst,
  // Filling side.
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Draining side.
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = (D > 1) ? $clog2(D) : 1;

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wr;
    logic [AW-1:0]       rd;
    logic [AW:0]         cnt;
    logic                full;
    logic                nonempty;
  } sdc_fifo_state_t;

  sdc_fifo_state_t s;
  sdc_fifo_state_t next_s;

  always_comb begin
    logic push;
    logic pop;
    push = in_valid & ~s.full;
    pop = out_ready & s.nonempty;
    next_s = s;
    if (push) begin
      next_s.mem[s.wr] = in_data;
      next_s.wr = (s.wr == AW'(D - 1)) ? '0 : s.wr + AW'(1);
    end
    if (pop) begin
      next_s.rd = (s.rd == AW'(D - 1)) ? '0 : s.rd + AW'(1);
    end
    next_s.cnt = s.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    next_s.full = (next_s.cnt == (AW + 1)'(D));
    next_s.nonempty = (next_s.cnt != '0);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign in_ready = ~s.full;
  assign out_valid = s.nonempty;
  assign out_data = s.mem[s.rd];

endmodule

// ==== src/sdc_pkg.sv ====
// Package of the host-side controller for a four-bank 16-bit synchronous DRAM.
// Assumes a 25 MHz system clock; the memory clock is derived from it by two.
package sdc_pkg;

  // Clock rates.
  localparam int CLK_PERIOD_NS = 40;
  localparam int SD_PERIOD_NS  = 2 * CLK_PERIOD_NS;

  // Timing figures and their counts in memory clock periods (ticks).
  localparam int INIT_WAIT_US         = 200;
  localparam int INIT_WAIT_TICKS      = (INIT_WAIT_US * 1000 + SD_PERIOD_NS - 1) / SD_PERIOD_NS;
  localparam int ROW_TO_COL_NS        = 20;
  localparam int ROW_TO_COL_TICKS     = (ROW_TO_COL_NS + SD_PERIOD_NS - 1) / SD_PERIOD_NS;
  localparam int MIN_ACTIVE_NS        = 50;
  localparam int MIN_ACTIVE_TICKS     = (MIN_ACTIVE_NS + SD_PERIOD_NS - 1) / SD_PERIOD_NS;
  localparam int PRECHARGE_NS         = 20;
  localparam int PRECHARGE_TICKS      = (PRECHARGE_NS + SD_PERIOD_NS - 1) / SD_PERIOD_NS;
  localparam int REFRESH_CYCLE_NS     = 70;
  localparam int REFRESH_CYCLE_TICKS  = (REFRESH_CYCLE_NS + SD_PERIOD_NS - 1) / SD_PERIOD_NS;
  localparam int MODE_TO_CMD_TICKS    = 2;
  localparam int WRITE_RECOVERY_TICKS = 2;
  localparam int REFRESH_PERIOD_MS    = 64;
  localparam int REFRESH_COUNT        = 4096;
  localparam int REFRESH_TICKS        = (REFRESH_PERIOD_MS * 1000000 / REFRESH_COUNT) / SD_PERIOD_NS;
  localparam int INIT_REFRESHES       = 2;
  localparam int WRITE_CLOSE_GAP      = (MIN_ACTIVE_TICKS - ROW_TO_COL_TICKS > WRITE_RECOVERY_TICKS) ?
                                        (MIN_ACTIVE_TICKS - ROW_TO_COL_TICKS) : WRITE_RECOVERY_TICKS;

  // Widths.
  localparam int DATA_W     = 16;
  localparam int ROW_W      = 12;
  localparam int COL_W      = 8;
  localparam int PIN_ADDR_W = 14;
  localparam int FIFO_DEPTH = 4;

  // Field positions of the mode words.
  localparam int MODE_LEN_LSB   = 0;
  localparam int MODE_ORDER_BIT = 3;
  localparam int MODE_LAT_LSB   = 4;
  localparam int MODE_WRITE_BIT = 9;
  localparam int EXT_DRIVE_LSB  = 5;
  localparam int AUTOCLOSE_BIT  = 10;

  // Field codes.
  localparam logic [2:0] LAT2          = 3'h2;
  localparam logic [2:0] LAT3          = 3'h3;
  localparam logic [2:0] LEN1          = 3'h0;
  localparam logic       ORDER_SEQ     = 1'h0;
  localparam logic       WRITE_SINGLE  = 1'h1;
  localparam logic [1:0] DRIVE_FULL    = 2'h0;
  localparam logic [1:0] DRIVE_HALF    = 2'h1;
  localparam logic [1:0] DRIVE_QUARTER = 2'h3;
  localparam logic [1:0] DRIVE_RSVD    = 2'h2;

  // Strobe patterns {row, column, write}, all active low.
  localparam logic [2:0] CMD_MODE     = 3'h0;
  localparam logic [2:0] CMD_REFRESH  = 3'h1;
  localparam logic [2:0] CMD_CLOSE    = 3'h2;
  localparam logic [2:0] CMD_ROW_OPEN = 3'h3;
  localparam logic [2:0] CMD_WRITE    = 3'h4;
  localparam logic [2:0] CMD_READ     = 3'h5;

  typedef struct packed {
    logic              we;
    logic [1:0]        bank;
    logic [ROW_W-1:0]  row;
    logic [COL_W-1:0]  col;
    logic [DATA_W-1:0] wdata;
  } sdc_req_t;

  // Memory pins; addr[13] and addr[12] are the bank lines.
  typedef struct packed {
    logic                  cke;
    logic                  cs_n;
    logic                  ras_n;
    logic                  cas_n;
    logic                  we_n;
    logic [PIN_ADDR_W-1:0] addr;
    logic [1:0]            dqm;
    logic [DATA_W-1:0]     dq;
    logic                  dq_oe;
  } sdc_pins_t;

  localparam sdc_pins_t PINS_NOP = '{cke: 1'h1, cs_n: 1'h0, ras_n: 1'h1, cas_n: 1'h1, we_n: 1'h1,
                                     addr: 14'h0, dqm: 2'h0, dq: 16'h0, dq_oe: 1'h0};

  typedef enum logic [3:0] {
    S_START,
    S_PWR_WAIT,
    S_INIT_REF,
    S_INIT_MODE,
    S_INIT_EXT,
    S_IDLE,
    S_COLUMN,
    S_READ_WAIT,
    S_CLOSE
  } sdc_state_t;

endpackage

// ==== verif/sdc_mem_model.sv ====
// Behavioural model of the four-bank 16-bit SDRAM that the controller drives.
// Assumes pins are settled at each sd_clk rise; counts every command breach it sees in viol.
`timescale 1ns/1ps
module sdc_mem_model
  import sdc_pkg::*;
#(
  parameter int INIT_TICKS = 4
) (
  // Link from the controller.
  input  wire logic         sd_clk,
  input  wire sdc_pins_t    pins,
  // Data back and observed state.
  output logic [DATA_W-1:0] dq_out,
  output logic [13:0]       mode_word,
  output logic [13:0]       ext_word,
  output int                n_ref,
  output int                viol
);
  logic [DATA_W-1:0] mem [int];
  logic [3:0]        open_b = 4'h0;
  logic [ROW_W-1:0]  row_of [4];
  int                open_age [4] = '{default: 99};
  int                pre_age = 99;
  int                tick = 0;
  int                ref_age = 0;
  int                init_ref = 0;
  logic              mode_ok = 1'b0;
  logic [DATA_W-1:0] rq [4];
  logic [3:0]        rq_v = 4'h0;
  logic [DATA_W-1:0] last = 16'h0;
  logic [DATA_W-1:0] old;
  logic [DATA_W-1:0] keep;
  logic [1:0]        ba;
  int                key;
  int                lat;
  initial begin
    mode_word = 14'h0;
    ext_word = 14'h0;
    n_ref = 0;
    viol = 0;
    dq_out = 16'h0;
  end
  always @(posedge sd_clk) begin
    ba = {pins.addr[12], pins.addr[13]};
    lat = int'(mode_word[6:4]);
    tick++;
    pre_age++;
    ref_age++;
    for (int b = 0; b < 4; b++) open_age[b]++;
    rq = '{rq[1], rq[2], rq[3], 16'h0};
    rq_v = rq_v >> 1;
    if (mode_ok && ref_age > REFRESH_TICKS + 16) begin
      viol++;
      ref_age = 0;
    end
    if (!pins.cs_n && {pins.ras_n, pins.cas_n, pins.we_n} != 3'h7) begin
      if (tick < INIT_TICKS) viol++;
      case ({pins.ras_n, pins.cas_n, pins.we_n})
        CMD_MODE: if (pins.addr[13:12] == 2'h0) begin
          if (init_ref < INIT_REFRESHES || pins.addr[11:10] != 2'h0 || pins.addr[8:7] != 2'h0) viol++;
          if (!(pins.addr[6:4] inside {LAT2, LAT3})) viol++;
          if (!(pins.addr[2:0] inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h7}) || pins.addr[3:0] == 4'hF) viol++;
          mode_word = pins.addr;
          mode_ok = 1'b1;
        end else if (pins.addr[13:12] == 2'h1) begin
          if (!mode_ok || pins.addr[4:0] != 5'h0 || pins.addr[11:7] != 5'h0) viol++;
          if (pins.addr[6:5] == DRIVE_RSVD) viol++;
          ext_word = pins.addr;
        end else viol++;
        CMD_REFRESH: begin
          if (open_b != 4'h0) viol++;
          n_ref++;
          init_ref++;
          ref_age = 0;
        end
        CMD_CLOSE: begin
          for (int b = 0; b < 4; b++)
            if ((pins.addr[10] || b == ba) && open_b[b] && open_age[b] < MIN_ACTIVE_TICKS) viol++;
          if (pins.addr[10]) open_b = 4'h0;
          else open_b[ba] = 1'b0;
          if (pins.addr[10]) init_ref = 0;
          pre_age = 0;
        end
        CMD_ROW_OPEN: begin
          if (!mode_ok || open_b[ba] || pre_age < PRECHARGE_TICKS) viol++;
          open_b[ba] = 1'b1;
          row_of[ba] = pins.addr[ROW_W-1:0];
          open_age[ba] = 0;
        end
        CMD_WRITE, CMD_READ: begin
          if (!open_b[ba] || open_age[ba] < ROW_TO_COL_TICKS) viol++;
          key = int'({ba, row_of[ba], pins.addr[COL_W-1:0]});
          old = mem.exists(key) ? mem[key] : 16'h0;
          keep = {{8{pins.dqm[1]}}, {8{pins.dqm[0]}}};
          if (!pins.we_n) begin
            if (!pins.dq_oe) viol++;
            mem[key] = (pins.dq & ~keep) | (old & keep);
          end else begin
            rq[lat-1] = old;
            rq_v[lat-1] = 1'b1;
          end
        end
        3'h6: rq_v = 4'h0;
        default: viol++;
      endcase
    end
    last = rq_v[0] ? rq[0] : ~last;
    dq_out <= last;
  end
endmodule

// ==== verif/test_sdc_ctrl.sv ====
// Self-checking bench of the SDRAM host controller with a memory model at its pins.
// Assumes the controller and the model share the shortened power-up wait.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, a, b); end end
module test_sdc_ctrl
  import sdc_pkg::*;
;
  logic              clk = 1'b0;
  logic              srst;
  logic              cfg_lat3;
  logic [1:0]        cfg_drive;
  logic              req_valid;
  logic              req_ready;
  sdc_req_t          req;
  logic              rd_valid;
  logic [DATA_W-1:0] rd_data;
  logic              init_done;
  logic              sd_clk;
  sdc_pins_t         sd_pins;
  logic [DATA_W-1:0] dq;
  logic [13:0]       mode_word;
  logic [13:0]       ext_word;
  int                n_ref;
  int                viol;
  int                err_count = 0;
  int                tests_run = 0;
  int                cyc = 0;
  int                t_rd = 0;
  int                lat_meas = 0;
  logic              was_rd = 1'b0;
  wire               is_rd = !sd_pins.cs_n && {sd_pins.ras_n, sd_pins.cas_n, sd_pins.we_n} == CMD_READ;
  always #20 clk = ~clk;
  sdc_ctrl #(.INIT_TICKS(4)) dut (.clk(clk), .srst(srst), .cfg_lat3(cfg_lat3), .cfg_drive(cfg_drive),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rd_valid(rd_valid), .rd_data(rd_data),
    .init_done(init_done), .sd_clk(sd_clk), .sd_pins(sd_pins), .sd_dq_in(dq));
  sdc_mem_model #(.INIT_TICKS(4)) mem (.sd_clk(sd_clk), .pins(sd_pins), .dq_out(dq), .mode_word(mode_word),
    .ext_word(ext_word), .n_ref(n_ref), .viol(viol));
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic send(input logic w, input logic [1:0] b, input logic [11:0] r, input logic [7:0] c,
                      input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    req_valid = 1'b1;
    req = '{we: w, bank: b, row: r, col: c, wdata: d};
    while (req_ready !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
  endtask
  task automatic drop;
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  task automatic rd_chk(input logic [1:0] b, input logic [11:0] r, input logic [7:0] c, input logic [15:0] e);
    int n;
    n = 0;
    send(1'b0, b, r, c, 16'h0);
    drop();
    while (rd_valid !== 1'b1 && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(rd_data, e)
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    was_rd <= is_rd;
    if (is_rd && !was_rd) t_rd <= cyc;
    if (rd_valid) lat_meas <= cyc - t_rd;
    if (cyc > 12000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    int n;
    int n0;
    logic [11:0] row;
    logic [7:0] col;
    srst = 1'b1;
    cfg_lat3 = 1'b0;
    cfg_drive = 2'h0;
    req_valid = 1'b0;
    req = '0;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      srst = 1'b1;
      cfg_lat3 = i[0];
      cfg_drive = i[1:0];
      row = (i == 3) ? 12'hFFF : 12'(i);
      col = i[0] ? 8'hFF : 8'h00;
      repeat (4) @(negedge clk);
      srst = 1'b0;
      for (int k = 0; k < 4; k++) send(1'b1, k[1:0], row, col, 16'(16'hA000 + 16 * i + k));
      drop();
      `CHK(req_ready, 1'b0)
      `CHK(init_done, 1'b0)
      n = 0;
      while (init_done !== 1'b1 && n < 500) begin
        @(negedge clk);
        n++;
      end
      repeat (2) @(negedge clk);
      `CHK(mode_word, {4'h0, WRITE_SINGLE, 2'h0, i[0] ? LAT3 : LAT2, ORDER_SEQ, LEN1})
      `CHK(ext_word, {1'h0, 1'h1, 5'h0, (i == 2) ? DRIVE_QUARTER : i[1:0], 5'h0})
      for (int k = 3; k >= 0; k--) rd_chk(k[1:0], row, col, 16'(16'hA000 + 16 * i + k));
      `CHK(lat_meas, 2 * (i[0] ? 4 : 3))
    end
    n0 = n_ref;
    repeat (1200) @(negedge clk);
    `CHK(n_ref - n0 >= 3, 1'b1)
    `CHK(viol, 0)
    end_sim();
  end
endmodule
